/* File: design/sld_cfg.svh */
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH
// link count and apb address width
`define SLD_NUM_LINKS      4
`define SLD_ADDR_W         12
// register byte offsets
`define SLD_CTRL_OFS       12'h000
`define SLD_FAST_DIV_OFS   12'h004
`define SLD_SLOW_DIV_OFS   12'h008
`define SLD_PULSE_DIV_OFS  12'h00C
`define SLD_IRQ_STAT_OFS   12'h010
`define SLD_IRQ_MASK_OFS   12'h014
`define SLD_LINK_STATE_OFS 12'h018
`define SLD_BOARD_STATE_OFS 12'h01C
// control fields and reset value
`define SLD_CTRL_LINK_EN   0
`define SLD_CTRL_BOARD_EN  1
`define SLD_CTRL_RST       32'h0000_0003
// interrupt status fields
`define SLD_IRQ_W          7
`define SLD_IRQ_OVC_LSB    0
`define SLD_IRQ_CAM        4
`define SLD_IRQ_HCLK       5
`define SLD_IRQ_L0         6
`define SLD_IRQ_MASK_RST   7'h00
// host bus codes
`define SLD_GEN3           2'h3
`define SLD_LANES_FULL     4'h8
// timing: clock period, flash half periods and pulse step
`define SLD_CLK_NS         10
`define SLD_FAST_HALF_MS   100
`define SLD_SLOW_HALF_MS   500
`define SLD_PULSE_STEP_MS  60
`define SLD_MS_TO_CYC(ms)  (((ms) * 1000000) / `SLD_CLK_NS)
`define SLD_FAST_CYC       `SLD_MS_TO_CYC(`SLD_FAST_HALF_MS)
`define SLD_SLOW_CYC       `SLD_MS_TO_CYC(`SLD_SLOW_HALF_MS)
`define SLD_PULSE_CYC      `SLD_MS_TO_CYC(`SLD_PULSE_STEP_MS)
`endif

/* File: design/sld_pkg.sv */
package sld_pkg;
  // link indicator patterns, one-hot
  typedef enum logic [8:0] {
    PAT_INIT     = 9'b0_0000_0001,
    PAT_OVERCUR  = 9'b0_0000_0010,
    PAT_NOCAM    = 9'b0_0000_0100,
    PAT_DET_PWR  = 9'b0_0000_1000,
    PAT_DET_NPWR = 9'b0_0001_0000,
    PAT_TEST     = 9'b0_0010_0000,
    PAT_XFER     = 9'b0_0100_0000,
    PAT_TRIG     = 9'b0_1000_0000,
    PAT_IDLE     = 9'b1_0000_0000
  } sld_pattern_type;
endpackage

/* File: design/sld_led_driver.sv */
// Function
// R1: each fiber link has its own red/green indicator driven from its status.
// R2: before system initialization every link indicator shows steady orange.
// R3: no camera on a link gives a slow red pulse.
// R4: detection flashes fast, green/orange with camera power, orange alone without.
// R5: camera connected with no data moving shows steady green.
// R6: camera connected and waiting for trigger gives slow orange pulse.
// R7: camera connected and data transferring flashes green fast.
// R8: test packets being sent flash slowly alternating green and orange.
// R9: heartbeat board LED blinks while host bus clock present, stops otherwise.
// R10: link-active board LED lit only while host bus is in L0.
// R11: speed board LED lit at third generation rate, dark at first or second.
// R12: width board LED lit when all eight lanes are up.
// R13: camera power over-current on a link shows steady red.
// R14: highest priority condition wins: init, overcurrent, nocam, detect, test, connected.
// R15: fast flash, slow flash, slow pulse come from programmable clock prescalers.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "sld_cfg.svh"
module sld_led_driver #(
  parameter int          NUM_LINKS = `SLD_NUM_LINKS,
  parameter logic [31:0] FAST_DIV  = 32'(`SLD_FAST_CYC - 1),
  parameter logic [31:0] SLOW_DIV  = 32'(`SLD_SLOW_CYC - 1),
  parameter logic [31:0] PULSE_DIV = 32'(`SLD_PULSE_CYC - 1)
) (
  // clock, reset, enable
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`SLD_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // link status
  input  wire logic                   sys_init_done,
  input  wire logic [NUM_LINKS-1:0]   cam_present,
  input  wire logic [NUM_LINKS-1:0]   conn_detect,
  input  wire logic [NUM_LINKS-1:0]   pocxp_on,
  input  wire logic [NUM_LINKS-1:0]   pocxp_fault,
  input  wire logic [NUM_LINKS-1:0]   trig_wait,
  input  wire logic [NUM_LINKS-1:0]   data_xfer,
  input  wire logic [NUM_LINKS-1:0]   test_pkt,
  // host bus status
  input  wire logic                   host_clk_alive,
  input  wire logic                   host_l0,
  input  wire logic [1:0]             host_gen,
  input  wire logic [3:0]             host_lanes,
  // indicators and interrupt
  output logic [NUM_LINKS-1:0]        link_led_red,
  output logic [NUM_LINKS-1:0]        link_led_green,
  output logic [3:0]                  board_led,
  output logic                        irq
);

  // priority selection of one link's pattern
  function automatic sld_pkg::sld_pattern_type pick(input logic init, input logic ovc,
      input logic cam, input logic det, input logic pwr, input logic tst,
      input logic xfr, input logic trg);
    if (!init)     pick = sld_pkg::PAT_INIT;     // R2 R14
    else if (ovc)  pick = sld_pkg::PAT_OVERCUR;  // R13 R14
    else if (!cam) pick = sld_pkg::PAT_NOCAM;    // R14
    else if (det)  pick = pwr ? sld_pkg::PAT_DET_PWR : sld_pkg::PAT_DET_NPWR; // R14
    else if (tst)  pick = sld_pkg::PAT_TEST;     // R14
    else if (xfr)  pick = sld_pkg::PAT_XFER;
    else if (trg)  pick = sld_pkg::PAT_TRIG;
    else           pick = sld_pkg::PAT_IDLE;
  endfunction

  // colour of a pattern as {red, green}; orange is both
  function automatic logic [1:0] colour(input sld_pkg::sld_pattern_type p,
      input logic fst, input logic slw, input logic pls);
    case (p)
      sld_pkg::PAT_INIT:     colour = 2'h3;        // R2
      sld_pkg::PAT_OVERCUR:  colour = 2'h2;        // R13
      sld_pkg::PAT_NOCAM:    colour = {pls, 1'b0}; // R3
      sld_pkg::PAT_DET_PWR:  colour = {fst, 1'b1}; // R4
      sld_pkg::PAT_DET_NPWR: colour = {fst, fst};  // R4
      sld_pkg::PAT_TEST:     colour = {slw, 1'b1}; // R8
      sld_pkg::PAT_XFER:     colour = {1'b0, fst}; // R7
      sld_pkg::PAT_TRIG:     colour = {pls, pls};  // R6
      sld_pkg::PAT_IDLE:     colour = 2'h1;        // R5
      default:               colour = 2'h0;
    endcase
  endfunction

  // readback code of a pattern: bit position of the one-hot value
  function automatic logic [3:0] code(input sld_pkg::sld_pattern_type p);
    code = 4'h0;
    for (int k = 0; k < 9; k++) begin
      if (p[k]) code = 4'(k);
    end
  endfunction

  // registers
  logic [31:0]            ctrl;
  logic [31:0]            presc_div [3];
  logic [`SLD_IRQ_W-1:0]  irq_status;
  logic [`SLD_IRQ_W-1:0]  irq_mask;
  logic [NUM_LINKS-1:0]   ovc_q;
  logic [NUM_LINKS-1:0]   cam_q;
  logic                   hclk_q;
  logic                   l0_q;
  logic [31:0]            presc_cnt [3];
  logic [2:0]             presc_ph;
  logic [4:0]             pulse_step;
  logic [3:0]             pwm_cnt;

  // apb decode
  wire logic setup     = psel & ~penable;
  wire logic wr_take   = psel & penable & pwrite & pready;
  wire logic hit_ctrl  = paddr == `SLD_CTRL_OFS;
  wire logic hit_fast  = paddr == `SLD_FAST_DIV_OFS;
  wire logic hit_slow  = paddr == `SLD_SLOW_DIV_OFS;
  wire logic hit_pulse = paddr == `SLD_PULSE_DIV_OFS;
  wire logic hit_stat  = paddr == `SLD_IRQ_STAT_OFS;
  wire logic hit_mask  = paddr == `SLD_IRQ_MASK_OFS;
  wire logic hit_link  = paddr == `SLD_LINK_STATE_OFS;
  wire logic hit_board = paddr == `SLD_BOARD_STATE_OFS;
  wire logic hit_any   = hit_ctrl | hit_fast | hit_slow | hit_pulse | hit_stat | hit_mask |
                         hit_link | hit_board;
  wire logic [2:0] div_wr = {3{wr_take & ~pslverr}} & {hit_pulse, hit_slow, hit_fast};

  // prescaler ticks and phases
  wire logic [2:0] presc_tick;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_presc
      assign presc_tick[gi] = presc_cnt[gi] >= presc_div[gi]; // R15
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          presc_cnt[gi] <= 32'h0000_0000;
          presc_ph[gi]  <= 1'b0;
        end else if (clk_en) begin
          presc_cnt[gi] <= presc_tick[gi] ? 32'h0000_0000 : presc_cnt[gi] + 32'h0000_0001;
          if (presc_tick[gi]) presc_ph[gi] <= ~presc_ph[gi]; // R15
        end
      end
    end
  endgenerate

  // slow pulse: triangle brightness against a free-running pwm count
  wire logic [3:0] bright = pulse_step[4] ? ~pulse_step[3:0] : pulse_step[3:0];
  wire logic       pulse  = pwm_cnt < bright; // R15
  wire logic       fast   = presc_ph[0];
  wire logic       slow   = presc_ph[1];
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pulse_step <= 5'h00;
      pwm_cnt    <= 4'h0;
    end else if (clk_en) begin
      pwm_cnt <= pwm_cnt + 4'h1;
      if (presc_tick[2]) pulse_step <= pulse_step + 5'h01;
    end
  end

  // per-link pattern selection and colour
  sld_pkg::sld_pattern_type   pat [NUM_LINKS];
  wire logic [NUM_LINKS-1:0]  next_red;
  wire logic [NUM_LINKS-1:0]  next_green;
  wire logic [31:0]           link_state_rd;
  generate
    for (gi = 0; gi < NUM_LINKS; gi++) begin : g_link
      assign pat[gi] = pick(sys_init_done, pocxp_fault[gi], cam_present[gi], conn_detect[gi],
                            pocxp_on[gi], test_pkt[gi], data_xfer[gi], trig_wait[gi]); // R1
      assign {next_red[gi], next_green[gi]} =
          colour(pat[gi], fast, slow, pulse) & {2{ctrl[`SLD_CTRL_LINK_EN]}}; // R1
      assign link_state_rd[4*gi +: 4] = code(pat[gi]);
    end
    if (NUM_LINKS < 8) begin : g_pad
      assign link_state_rd[31:4*NUM_LINKS] = '0;
    end
  endgenerate

  // board indicators
  wire logic [3:0] board_raw = {host_lanes == `SLD_LANES_FULL, // R12
                                host_gen == `SLD_GEN3,         // R11
                                host_l0,                       // R10
                                host_clk_alive & slow};        // R9
  wire logic [3:0] next_board = board_raw & {4{ctrl[`SLD_CTRL_BOARD_EN]}};

  // interrupt events; a new event beats a same-cycle clear
  wire logic [3:0] ovc_rise = 4'(pocxp_fault & ~ovc_q);
  wire logic [`SLD_IRQ_W-1:0] irq_evt = {l0_q & ~host_l0, hclk_q & ~host_clk_alive,
                                         |(cam_present ^ cam_q), ovc_rise};
  wire logic [`SLD_IRQ_W-1:0] irq_clr = (wr_take & hit_stat) ? pwdata[`SLD_IRQ_W-1:0] : '0;
  wire logic [`SLD_IRQ_W-1:0] next_status = (irq_status & ~irq_clr) | irq_evt;

  // read mux
  wire logic [31:0] rd_mux =
      hit_ctrl  ? ctrl :
      hit_fast  ? presc_div[0] :
      hit_slow  ? presc_div[1] :
      hit_pulse ? presc_div[2] :
      hit_stat  ? 32'(irq_status) :
      hit_mask  ? 32'(irq_mask) :
      hit_link  ? link_state_rd :
      hit_board ? {24'h00_0000, board_raw, board_led} : 32'h0000_0000;

  // apb answer: ready in the access cycle, read data and error captured at setup
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~hit_any;
      end
    end
  end

  // writable registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl         <= `SLD_CTRL_RST;
      presc_div[0] <= FAST_DIV;
      presc_div[1] <= SLOW_DIV;
      presc_div[2] <= PULSE_DIV;
      irq_mask     <= `SLD_IRQ_MASK_RST;
    end else if (clk_en && wr_take && !pslverr) begin
      if (hit_ctrl) ctrl <= pwdata & `SLD_CTRL_RST;
      if (hit_mask) irq_mask <= pwdata[`SLD_IRQ_W-1:0];
      for (int k = 0; k < 3; k++) begin
        if (div_wr[k]) presc_div[k] <= pwdata; // R15
      end
    end
  end

  // status, event history and interrupt line
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_status <= '0;
      ovc_q      <= '0;
      cam_q      <= '0;
      hclk_q     <= 1'b0;
      l0_q       <= 1'b0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      irq_status <= next_status;
      ovc_q      <= pocxp_fault;
      cam_q      <= cam_present;
      hclk_q     <= host_clk_alive;
      l0_q       <= host_l0;
      irq        <= |(next_status & irq_mask);
    end
  end

  // registered indicator outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link_led_red   <= '0;
      link_led_green <= '0;
      board_led      <= 4'h0;
    end else if (clk_en) begin
      link_led_red   <= next_red;   // R1
      link_led_green <= next_green; // R1
      board_led      <= next_board; // R9 R10 R11 R12
    end
  end

endmodule // sld_led_driver
`default_nettype wire

/* File: bench/sld_led_driver_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sld_cfg.svh"
module sld_led_checker #(
  parameter int NUM_LINKS = 4
) (
  // clock, reset and status inputs
  input wire logic                 sys_clk, reset, sys_init_done, host_clk_alive, host_l0,
  input wire logic [NUM_LINKS-1:0] cam_present, conn_detect, pocxp_on, pocxp_fault,
  input wire logic [NUM_LINKS-1:0] trig_wait, data_xfer, test_pkt,
  input wire logic [1:0]           host_gen,
  input wire logic [3:0]           host_lanes,
  // indicators
  input wire logic [NUM_LINKS-1:0] link_led_red, link_led_green,
  input wire logic [3:0]           board_led
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // link 0 connected with nothing of higher rank pending
  wire logic con0 = sys_init_done & ~pocxp_fault[0] & cam_present[0] & ~conn_detect[0];
  wire logic act0 = test_pkt[0] | data_xfer[0];
  // link colours one cycle after the status
  property p_init; !sys_init_done |=> &link_led_red && &link_led_green; endproperty
  a_init: assert property (p_init) else $error("link not orange before init");
  property p_fault; sys_init_done |=> (link_led_green & $past(pocxp_fault)) == '0
    && (link_led_red & $past(pocxp_fault)) == $past(pocxp_fault); endproperty
  a_fault: assert property (p_fault) else $error("faulty link not steady red");
  property p_nocam; sys_init_done && !pocxp_fault[0] && !cam_present[0] |=> !link_led_green[0]; endproperty
  a_nocam: assert property (p_nocam) else $error("green lit without camera");
  property p_det; sys_init_done && !pocxp_fault[0] && cam_present[0] && conn_detect[0] && !pocxp_on[0]
    |=> link_led_red[0] == link_led_green[0]; endproperty
  a_det: assert property (p_det) else $error("detect flash not orange");
  property p_test; con0 && test_pkt[0] |=> link_led_green[0]; endproperty
  a_test: assert property (p_test) else $error("test flash lost green");
  property p_xfer; con0 && !test_pkt[0] && data_xfer[0] |=> !link_led_red[0]; endproperty
  a_xfer: assert property (p_xfer) else $error("red lit in transfer");
  property p_trig; con0 && !act0 && trig_wait[0] |=> link_led_red[0] == link_led_green[0]; endproperty
  a_trig: assert property (p_trig) else $error("trigger pulse not orange");
  property p_idle; con0 && !act0 && !trig_wait[0] |=> link_led_green[0] && !link_led_red[0]; endproperty
  a_idle: assert property (p_idle) else $error("idle link not green");
  // board indicators
  property p_beat; !host_clk_alive |=> !board_led[0]; endproperty
  a_beat: assert property (p_beat) else $error("heartbeat without host clock");
  property p_l0; 1'b1 |=> board_led[1] == $past(host_l0); endproperty
  a_l0: assert property (p_l0) else $error("link active led wrong");
  property p_gen; 1'b1 |=> board_led[2] == ($past(host_gen) == `SLD_GEN3); endproperty
  a_gen: assert property (p_gen) else $error("speed led wrong");
  property p_lane; 1'b1 |=> board_led[3] == ($past(host_lanes) == `SLD_LANES_FULL); endproperty
  a_lane: assert property (p_lane) else $error("width led wrong");
endmodule // sld_led_checker
`default_nettype wire

/* File: bench/sld_led_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sld_led_model #(
  parameter int W = 9
) (
  // clock and counter clear
  input  wire logic         sys_clk,
  input  wire logic         clr,
  // observed indicators and their change counts
  input  wire logic [W-1:0] leds,
  output logic [W-1:0][7:0] edges
);
  logic [W-1:0] leds_q;
  // count level changes of every lamp since the last clear
  always_ff @(posedge sys_clk) begin
    leds_q <= leds;
    for (int i = 0; i < W; i++) begin
      edges[i] <= clr ? 8'h00 : edges[i] + 8'(leds[i] != leds_q[i]);
    end
  end
endmodule // sld_led_model
`default_nettype wire

/* File: bench/sld_led_driver_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sld_cfg.svh"
module sld_led_driver_test;
  localparam int N = `SLD_NUM_LINKS;
  // stimulus, outputs and bookkeeping
  logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, sys_init_done = 0, clr = 1;
  logic host_clk_alive = 0, host_l0 = 0, clk_en = 1, er, pready, pslverr, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata;
  logic [1:0] host_gen = '0;
  logic [3:0] host_lanes = '0, board_led;
  logic [N-1:0] cam_present = '0, conn_detect = '0, pocxp_on = '0, pocxp_fault = '0;
  logic [N-1:0] trig_wait = '0, data_xfer = '0, test_pkt = '0, link_led_red, link_led_green;
  logic [2*N:0][7:0] edges;
  logic [2:0] pa [N];
  logic [6:0] v;
  int n_errors = 0, n_checks = 0, seed = 44;
  int exp_r [8] = '{1, 4, 2, 2, 3, 0, 4, 0};
  int exp_g [8] = '{0, 0, 1, 2, 1, 2, 4, 1};
  sld_led_driver #(.FAST_DIV(32'h0000_0003), .SLOW_DIV(32'h0000_0017), .PULSE_DIV(32'h0000_0001)) i_dut (
    .sys_clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .sys_init_done, .cam_present, .conn_detect, .pocxp_on, .pocxp_fault, .trig_wait, .data_xfer, .test_pkt,
    .host_clk_alive, .host_l0, .host_gen, .host_lanes, .link_led_red, .link_led_green, .board_led, .irq);
  sld_led_model #(.W(2*N+1)) i_led (.sys_clk, .clr, .leds({board_led[0], link_led_green, link_led_red}), .edges);
  // clock and hang guard
  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    give_verdict;
  end
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      give_verdict;
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task irq_is(input logic e);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // clear the lamp change counters, then let n cycles pass
  task watch(input int n);
    clr <= 1'b1;
    repeat (3) @(posedge sys_clk);
    clr <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  // classify a lamp: 0/1 steady, 2 fast, 3 slow, 4 pulse
  function automatic logic [31:0] mode(input logic [7:0] c, input logic lvl);
    if ($isunknown(c)) return 32'hxxxx_xxxx;
    if (c == 8'h00) return {31'h0, lvl};
    if (c >= 8'h17 && c <= 8'h19) return 32'h0000_0002;
    if (c >= 8'h03 && c <= 8'h05) return 32'h0000_0003;
    return 32'h0000_0004;
  endfunction
  // set one link to a pattern, lower ranked conditions random
  task drive(input int i, input logic [2:0] p);
    v = 7'($random(seed));
    v[3] = p == 3'h0;
    if (p != 3'h0) v[6] = p != 3'h1;
    if (p > 3'h1) v[5] = p < 3'h4;
    if (p inside {3'h2, 3'h3}) v[4] = p == 3'h2;
    if (p > 3'h3) v[0] = p == 3'h4;
    if (p > 3'h4) v[1] = p == 3'h5;
    if (p > 3'h5) v[2] = p == 3'h6;
    {cam_present[i], conn_detect[i], pocxp_on[i], pocxp_fault[i], trig_wait[i], data_xfer[i], test_pkt[i]} <= v;
  endtask
  // main sequence: registers, indicator patterns, interrupt
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, `SLD_CTRL_OFS, '0);
    chk(rd, `SLD_CTRL_RST);
    apb(1'b0, `SLD_FAST_DIV_OFS, '0);
    chk(rd, 32'h0000_0003);
    apb(1'b0, 12'h020, '0);
    chk({31'h0, er}, 32'h0000_0001);
    for (int s = 0; s < 12; s++) begin
      sys_init_done <= s > 0;
      host_clk_alive <= 1'($random(seed));
      host_l0 <= 1'($random(seed));
      host_gen <= 2'(s % 3 + 1);
      host_lanes <= s % 2 ? 4'h8 : (s % 4 ? 4'h4 : 4'h1);
      for (int i = 0; i < N; i++) begin
        pa[i] = s < 9 ? 3'((s + 3 * i) % 8) : 3'($random(seed));
        drive(i, pa[i]);
      end
      watch(96);
      for (int i = 0; i < N; i++) begin
        chk(mode(edges[i], link_led_red[i]), s ? exp_r[pa[i]] : 1);
        chk(mode(edges[N+i], link_led_green[i]), s ? exp_g[pa[i]] : 1);
      end
      chk(mode(edges[2*N], board_led[0]), host_clk_alive ? 3 : 0);
      chk(32'(board_led[3:1]), 32'({host_lanes == 4'h8, host_gen == 2'h3, host_l0}));
    end
    // corner cases: link lamps gated off, pattern readback, freeze by the clock enable
    for (int i = 0; i < N; i++) begin
      drive(i, 3'h2);
    end
    apb(1'b1, `SLD_CTRL_OFS, 32'h0000_0002);
    apb(1'b0, `SLD_LINK_STATE_OFS, '0);
    chk(rd, 32'h0000_3333);
    watch(40);
    chk(mode(edges[0], link_led_red[0]), 0);
    chk(mode(edges[N], link_led_green[0]), 0);
    chk({31'h0, board_led[1]}, {31'h0, host_l0});
    apb(1'b1, `SLD_CTRL_OFS, `SLD_CTRL_RST);
    repeat (2) @(posedge sys_clk);
    clk_en <= 1'b0;
    watch(40);
    chk(32'(edges[0]), 0);
    clk_en <= 1'b1;
    watch(96);
    chk(mode(edges[0], link_led_red[0]), 2);
    chk(mode(edges[N], link_led_green[0]), 1);
    pocxp_fault <= '0;
    apb(1'b1, `SLD_IRQ_MASK_OFS, 32'h0000_0001);
    apb(1'b1, `SLD_IRQ_STAT_OFS, 32'h0000_007F);
    irq_is(1'b0);
    pocxp_fault[0] <= 1'b1;
    irq_is(1'b1);
    apb(1'b1, `SLD_IRQ_MASK_OFS, 32'h0000_0000);
    irq_is(1'b0);
    apb(1'b1, `SLD_IRQ_MASK_OFS, 32'h0000_0001);
    irq_is(1'b1);
    apb(1'b1, `SLD_IRQ_STAT_OFS, 32'h0000_0001);
    irq_is(1'b0);
    give_verdict;
  end
endmodule // sld_led_driver_test
bind sld_led_driver sld_led_checker #(.NUM_LINKS(NUM_LINKS)) i_chk (.sys_clk, .reset, .sys_init_done,
  .host_clk_alive, .host_l0, .cam_present, .conn_detect, .pocxp_on, .pocxp_fault, .trig_wait, .data_xfer,
  .test_pkt, .host_gen, .host_lanes, .link_led_red, .link_led_green, .board_led);
`default_nettype wire
